// ### rtl/dqd_decoder.sv
// Command decoder and register set of a quad 8-bit converter on a two-wire bus.
// Assumes scl and sda arrive asynchronously and are oversampled by clk_in (50 MHz).
//
// Behaviour
// - Mode 00: store data in picked temporary only
// - Mode 10: picked gets data, others load temporaries
// - Broadcast, bit two clear: all outputs from temporaries
// - Broadcast, bit two set, no power-down: all outputs get data
// - Broadcast, bit two set, with power-down: code to all channels
// - Power-down flag: upper bits 7,6 are code
// - Normal write: upper byte is 8-bit code
// - Update waits for the ignored low byte
// - Commit at falling clock ending low-byte acknowledge
// - Readback storage cleared to zero at reset
// - Command byte latched into 8-bit register
// - Upper byte held in 8-bit register
// - 10-bit temporary per channel, code plus data
// - 10-bit output register per channel, immediate effect
// - Mode 01: picked temporary and output get data
// - Address 10011 plus two strapped pins
// - Broadcast address accepted for writes only
// - High-speed master code is not acknowledged
`timescale 1ns/1ns
module dqd_decoder (
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe_out,
   input  wire logic              addr_pin_hi_in,
   input  wire logic              addr_pin_lo_in,
   output logic [7:0]             command_byte_out,
   output logic [7:0]             upper_data_byte_out,
   output dqd_pkg::dqd_word_t     output_reg_chan_a_out,
   output dqd_pkg::dqd_word_t     output_reg_chan_b_out,
   output dqd_pkg::dqd_word_t     output_reg_chan_c_out,
   output dqd_pkg::dqd_word_t     output_reg_chan_d_out,
   output logic                   commit_out
);
   import dqd_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic       scl_s;
   logic       sda_s;
   logic       pin_hi_s;
   logic       pin_lo_s;
   logic       scl_prev;
   logic       sda_prev;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;

   dqd_sync #(.RESET_VAL(1'b1)) u_sync_scl (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in (scl_in),
      .sync_out (scl_s)
   );

   dqd_sync #(.RESET_VAL(1'b1)) u_sync_sda (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in (sda_in),
      .sync_out (sda_s)
   );

   dqd_sync #(.RESET_VAL(1'b0)) u_sync_pin_hi (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in (addr_pin_hi_in),
      .sync_out (pin_hi_s)
   );

   dqd_sync #(.RESET_VAL(1'b0)) u_sync_pin_lo (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .async_in (addr_pin_lo_in),
      .sync_out (pin_lo_s)
   );

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_s;
         sda_prev <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_prev;
   assign scl_fall  = ~scl_s & scl_prev;
   // Data edges while the clock stays high frame the transfer
   assign bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
   assign bus_stop  = scl_s & scl_prev & ~sda_prev & sda_s;

   // ----------------------------------------------------------------
   // Address strap capture
   // ----------------------------------------------------------------
   logic [1:0] strap_cnt;
   logic       strap_done;
   logic [1:0] own_pins;

   // pins caught once
   // Waits out the synchroniser so the caught level is the real pin state
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         strap_cnt  <= 2'h0;
         strap_done <= 1'b0;
         own_pins   <= 2'h0;
      end else if (!strap_done) begin
         if (strap_cnt == STRAP_WAIT) begin
            strap_done <= 1'b1;
            own_pins   <= {pin_hi_s, pin_lo_s};
         end else begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Byte receiver
   // ----------------------------------------------------------------
   dqd_phase_t phase;
   logic [3:0] bit_cnt;
   logic [7:0] shift_reg;
   logic       in_ack;
   logic       ack_given;
   logic       byte_full;
   logic       ack_end;
   logic       addr_own;
   logic       addr_bcast;
   logic       accept_byte;
   logic       commit;

   assign byte_full = (bit_cnt == BITS_PER_BYTE);
   assign ack_end   = scl_fall & in_ack;

   assign addr_own  = (shift_reg[7:ADDR_FIXED_LSB] == ADDR_FIXED)
                    & (shift_reg[ADDR_PIN_HI_BIT:ADDR_PIN_LO_BIT] == own_pins)
                    & ~shift_reg[ADDR_RW_BIT];
   assign addr_bcast = (shift_reg == ADDR_BROADCAST);

   // master code matches neither, so no acknowledge
   always_comb begin
      accept_byte = 1'b0;
      unique case (phase)
         PH_IDLE: accept_byte = 1'b0;
         PH_ADDR: accept_byte = strap_done & (addr_own | addr_bcast);
         PH_CTRL: accept_byte = 1'b1;
         PH_HIGH: accept_byte = 1'b1;
         PH_LOW:  accept_byte = 1'b1;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         shift_reg <= BYTE_RESET;
      end else if (scl_rise && !in_ack && !byte_full) begin
         shift_reg <= {shift_reg[6:0], sda_s};
      end
   end

   // Phase, bit count and acknowledge driver
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         phase      <= PH_IDLE;
         bit_cnt    <= BIT_CNT_RESET;
         in_ack     <= 1'b0;
         ack_given  <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (bus_start) begin
         phase      <= PH_ADDR;
         bit_cnt    <= BIT_CNT_RESET;
         in_ack     <= 1'b0;
         ack_given  <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (bus_stop) begin
         phase      <= PH_IDLE;
         bit_cnt    <= BIT_CNT_RESET;
         in_ack     <= 1'b0;
         ack_given  <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (phase != PH_IDLE) begin
         if (scl_rise && !in_ack && !byte_full) begin
            bit_cnt <= bit_cnt + 4'h1;
         end else if (scl_fall && byte_full && !in_ack) begin
            in_ack     <= 1'b1;
            ack_given  <= accept_byte;
            sda_oe_out <= accept_byte;
         end else if (ack_end) begin
            in_ack     <= 1'b0;
            bit_cnt    <= BIT_CNT_RESET;
            sda_oe_out <= 1'b0;
            if (!ack_given) begin
               phase <= PH_IDLE;
            end else begin
               unique case (phase)
                  PH_ADDR: phase <= PH_CTRL;
                  PH_CTRL: phase <= PH_HIGH;
                  PH_HIGH: phase <= PH_LOW;
                  PH_LOW:  phase <= PH_HIGH;
                  PH_IDLE: phase <= PH_IDLE;
               endcase
            end
         end
      end
   end

   // Open-drain: only ever pulls low
   always_ff @(posedge clk_in) begin
      sda_out <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Command and upper byte registers
   // ----------------------------------------------------------------
   logic [7:0] command_byte_reg;
   logic [7:0] upper_data_byte_reg;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         command_byte_reg    <= BYTE_RESET;
         upper_data_byte_reg <= BYTE_RESET;
      end else if (ack_end && ack_given) begin
         if (phase == PH_CTRL) begin
            command_byte_reg <= shift_reg;
         end
         if (phase == PH_HIGH) begin
            upper_data_byte_reg <= shift_reg;
         end
      end
   end

   assign command_byte_out    = command_byte_reg;
   assign upper_data_byte_out = upper_data_byte_reg;

   // ----------------------------------------------------------------
   // Commit decode
   // ----------------------------------------------------------------
   logic [1:0] update_mode;
   logic [1:0] channel_pick;
   logic       powerdown_flag;
   logic [1:0] powerdown_code;

   // low byte content unused; it only gates the update
   // update on the falling edge ending the low-byte acknowledge
   assign commit = ack_end & ack_given & (phase == PH_LOW);

   assign update_mode    = {command_byte_reg[CMD_MODE_HI_BIT], command_byte_reg[CMD_MODE_LO_BIT]};
   assign channel_pick   = {command_byte_reg[CMD_PICK_HI_BIT], command_byte_reg[CMD_PICK_LO_BIT]};
   assign powerdown_flag = command_byte_reg[CMD_PD_BIT];
   assign powerdown_code = {upper_data_byte_reg[PD_CODE_HI_BIT], upper_data_byte_reg[PD_CODE_LO_BIT]};

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         commit_out <= 1'b0;
      end else begin
         commit_out <= commit;
      end
   end

   // ----------------------------------------------------------------
   // Channel registers
   // ----------------------------------------------------------------
   dqd_word_t temp_reg [NUM_CHANNELS];
   dqd_word_t out_reg  [NUM_CHANNELS];

   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      logic      picked;
      dqd_word_t new_word;

      assign picked = (channel_pick == 2'(ch));

      // full byte as code, power-down bits cleared
      // power-down keeps the data bits, replaces the code
      assign new_word = powerdown_flag ? {powerdown_code, temp_reg[ch][DATA_W-1:0]}
                                       : {PD_NORMAL, upper_data_byte_reg};

      always_ff @(posedge clk_in) begin
         if (reset_in) begin
            temp_reg[ch] <= WORD_RESET;
         end else if (commit && picked && (update_mode != MODE_BROADCAST)) begin
            // temporary written in modes 00, 01, 10
            temp_reg[ch] <= new_word;
         end
      end

      // output register drives the channel directly
      always_ff @(posedge clk_in) begin
         if (reset_in) begin
            out_reg[ch] <= WORD_RESET;
         end else if (commit) begin
            unique case (update_mode)
               MODE_STORE: out_reg[ch] <= out_reg[ch];
               MODE_LOAD_ONE: begin
                  if (picked) begin
                     out_reg[ch] <= new_word;
                  end
               end
               MODE_LOAD_ALL: begin
                  if (picked) begin
                     out_reg[ch] <= new_word;
                  end else begin
                     out_reg[ch] <= temp_reg[ch];
                  end
               end
               // only bits two and zero steer broadcast
               MODE_BROADCAST: begin
                  if (!command_byte_reg[CMD_PICK_HI_BIT]) begin
                     out_reg[ch] <= temp_reg[ch];
                  end else if (!powerdown_flag) begin
                     out_reg[ch] <= {PD_NORMAL, upper_data_byte_reg};
                  end else begin
                     out_reg[ch] <= {powerdown_code, out_reg[ch][DATA_W-1:0]};
                  end
               end
            endcase
         end
      end
   end

   assign output_reg_chan_a_out = out_reg[0];
   assign output_reg_chan_b_out = out_reg[1];
   assign output_reg_chan_c_out = out_reg[2];
   assign output_reg_chan_d_out = out_reg[3];

endmodule : dqd_decoder

// ### rtl/dqd_pkg.sv
// Constants and types for the quad converter command decoder.
// Assumes a single 50 MHz system clock; the serial bus is sampled, not clocked.
package dqd_pkg;

   // ----------------------------------------------------------------
   // Addressing
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_FIXED      = 5'h13;
   localparam logic [7:0] ADDR_BROADCAST  = 8'h90;
   localparam int         ADDR_FIXED_LSB  = 3;
   localparam int         ADDR_PIN_HI_BIT = 2;
   localparam int         ADDR_PIN_LO_BIT = 1;
   localparam int         ADDR_RW_BIT     = 0;

   // ----------------------------------------------------------------
   // Command byte fields
   // ----------------------------------------------------------------
   localparam int         CMD_MODE_HI_BIT = 5;
   localparam int         CMD_MODE_LO_BIT = 4;
   localparam int         CMD_PICK_HI_BIT = 2;
   localparam int         CMD_PICK_LO_BIT = 1;
   localparam int         CMD_PD_BIT      = 0;
   localparam logic [1:0] MODE_STORE      = 2'h0;
   localparam logic [1:0] MODE_LOAD_ONE   = 2'h1;
   localparam logic [1:0] MODE_LOAD_ALL   = 2'h2;
   localparam logic [1:0] MODE_BROADCAST  = 2'h3;

   // ----------------------------------------------------------------
   // Upper data byte and channel words
   // ----------------------------------------------------------------
   localparam int         PD_CODE_HI_BIT  = 7;
   localparam int         PD_CODE_LO_BIT  = 6;
   localparam int         NUM_CHANNELS    = 4;
   localparam int         DATA_W          = 8;
   localparam int         WORD_W          = 10;
   localparam logic [1:0] PD_NORMAL       = 2'h0;
   localparam logic [7:0] BYTE_RESET      = 8'h00;
   localparam logic [9:0] WORD_RESET      = 10'h000;

   // ----------------------------------------------------------------
   // Bit counting and strap timing
   // ----------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [3:0] BIT_CNT_RESET   = 4'h0;
   localparam logic [1:0] STRAP_WAIT      = 2'h3;

   typedef logic [WORD_W-1:0] dqd_word_t;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_CTRL,
      PH_HIGH,
      PH_LOW
   } dqd_phase_t;

endpackage : dqd_pkg

// ### rtl/dqd_sync.sv
// Two-stage synchroniser for one asynchronous input.
// Assumes the input may change at any time relative to clk_in.
`timescale 1ns/1ns
module dqd_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta     <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : dqd_sync

// ### test/dqd_decoder_tb.sv
// Self-checking bench for the command decoder with a bus master model.
// Assumes straps 10 at start; the data line is wired-AND with a pull-up.
`timescale 1ns/1ns
module dqd_decoder_tb;
   import dqd_pkg::*;
   typedef struct packed {
      logic [7:0] ad;
      logic [7:0] ct;
      logic [7:0] hi;
      dqd_word_t  ea;
      dqd_word_t  eb;
      dqd_word_t  ec;
      dqd_word_t  ed;
   } dqd_row_t;

   logic       clk_in, reset_in, scl_in, sda_in, sda_out, sda_oe_out, m_oe, commit_out, ok;
   logic       addr_pin_hi_in, addr_pin_lo_in;
   logic [7:0] command_byte_out, upper_data_byte_out;
   dqd_word_t  output_reg_chan_a_out, output_reg_chan_b_out, output_reg_chan_c_out, output_reg_chan_d_out;
   wire logic [39:0] all_w;
   int         n_mismatch, n_compared;
   logic [7:0] bad [4] = '{8'h98, 8'h9D, 8'h91, 8'h0B};
   dqd_row_t   rows [12] = '{
      '{8'h9C, 8'h00, 8'h5A, 10'h000, 10'h000, 10'h000, 10'h000},
      '{8'h9C, 8'h12, 8'hC3, 10'h000, 10'h0C3, 10'h000, 10'h000},
      '{8'h9C, 8'h04, 8'h7E, 10'h000, 10'h0C3, 10'h000, 10'h000},
      '{8'h9C, 8'h26, 8'h81, 10'h05A, 10'h0C3, 10'h07E, 10'h081},
      '{8'h9C, 8'h13, 8'h80, 10'h05A, 10'h2C3, 10'h07E, 10'h081},
      '{8'h90, 8'h34, 8'hFF, 10'h0FF, 10'h0FF, 10'h0FF, 10'h0FF},
      '{8'h90, 8'hFA, 8'h00, 10'h05A, 10'h2C3, 10'h07E, 10'h081},
      '{8'h9C, 8'h37, 8'h40, 10'h15A, 10'h1C3, 10'h17E, 10'h181},
      '{8'h9C, 8'h21, 8'hC0, 10'h35A, 10'h2C3, 10'h07E, 10'h081},
      '{8'h9C, 8'h01, 8'h00, 10'h35A, 10'h2C3, 10'h07E, 10'h081},
      '{8'h90, 8'h30, 8'h00, 10'h05A, 10'h2C3, 10'h07E, 10'h081},
      '{8'h9C, 8'h12, 8'h11, 10'h05A, 10'h011, 10'h07E, 10'h081}};

   assign all_w  = {output_reg_chan_a_out, output_reg_chan_b_out, output_reg_chan_c_out, output_reg_chan_d_out};
   assign sda_in = ~(m_oe | (sda_oe_out & ~sda_out));

   dqd_decoder dqd_decoder_i (.clk_in, .reset_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .addr_pin_hi_in,
      .addr_pin_lo_in, .command_byte_out, .upper_data_byte_out, .output_reg_chan_a_out, .output_reg_chan_b_out,
      .output_reg_chan_c_out, .output_reg_chan_d_out, .commit_out);
   dqd_master dqd_master_i (.scl_out(scl_in), .sda_oe_out(m_oe), .sda_in(sda_in));

   always #10 clk_in = ~clk_in;

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic send3(input logic [23:0] b);
      dqd_master_i.start_cond();
      dqd_master_i.send_byte(b[23:16], ok);
      dqd_master_i.send_byte(b[15:8], ok);
      dqd_master_i.send_byte(b[7:0], ok);
   endtask : send3

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      clk_in         = 1'b0;
      reset_in       = 1'b1;
      addr_pin_hi_in = 1'b1;
      addr_pin_lo_in = 1'b0;
      n_mismatch     = 0;
      n_compared     = 0;
      repeat (10) @(posedge clk_in);
      #2 reset_in = 1'b0;
      repeat (20) @(posedge clk_in);
      check(all_w, 40'h0);
      foreach (rows[i]) begin
         @(posedge clk_in);
         #2 dqd_master_i.write(rows[i].ad, rows[i].ct, rows[i].hi, ok);
         check(ok, 1'b1);
         check(command_byte_out, rows[i].ct);
         check(upper_data_byte_out, rows[i].hi);
         check(all_w, {rows[i].ea, rows[i].eb, rows[i].ec, rows[i].ed});
      end
      // Foreign strap, read, broadcast read, high-speed master code
      foreach (bad[i]) begin
         dqd_master_i.start_cond();
         dqd_master_i.send_byte(bad[i], ok);
         check(ok, 1'b0);
      end
      dqd_master_i.write(8'h9C, 8'h12, 8'h44, ok);
      check({ok, all_w}, {1'b1, 10'h05A, 10'h044, 10'h07E, 10'h081});
      // Low byte cut off by a stop must not update
      send3({8'h9C, 8'h12, 8'h77});
      dqd_master_i.stop_cond();
      check(all_w, {10'h05A, 10'h044, 10'h07E, 10'h081});
      send3({8'h9C, 8'h12, 8'h22});
      dqd_master_i.send_byte(8'h00, ok);
      // Ack clock has just fallen at the pin; the update lands a few cycles later
      check(all_w, {10'h05A, 10'h044, 10'h07E, 10'h081});
      repeat (6) @(posedge clk_in);
      #2 check(all_w, {10'h05A, 10'h022, 10'h07E, 10'h081});
      dqd_master_i.send_byte(8'h33, ok);
      dqd_master_i.send_byte(8'h00, ok);
      dqd_master_i.stop_cond();
      check(all_w, {10'h05A, 10'h033, 10'h07E, 10'h081});
      // Reset in mid-run, new strap value taken afterwards
      @(posedge clk_in);
      #2 reset_in = 1'b1;
      addr_pin_lo_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #2 check({command_byte_out, upper_data_byte_out, all_w}, 64'h0);
      reset_in = 1'b0;
      repeat (20) @(posedge clk_in);
      #2 dqd_master_i.write(8'h9E, 8'h18, 8'h3C, ok);
      check({ok, all_w}, {1'b1, 10'h03C, 30'h0});
      complete_run();
   end
endmodule : dqd_decoder_tb

// ### test/dqd_master.sv
// Behavioural two-wire bus master for the decoder's serial pins.
// Assumes pull-ups on both lines; data is open drain, clock pushed.
`timescale 1ns/1ns
module dqd_master (
   output logic      scl_out,
   output logic      sda_oe_out,
   input  wire logic sda_in
);
   // Bus idles released
   initial begin
      scl_out    = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic start_cond();
      sda_oe_out = 1'b0;
      #80 scl_out = 1'b1;
      #60 sda_oe_out = 1'b1;
      #60 scl_out = 1'b0;
      #40;
   endtask : start_cond

   task automatic stop_cond();
      sda_oe_out = 1'b1;
      #60 scl_out = 1'b1;
      #60 sda_oe_out = 1'b0;
      #100;
   endtask : stop_cond

   // Late data change leaves the slave time to drop its acknowledge
   task automatic put_bit(input logic b, output logic seen);
      sda_oe_out = ~b;
      #60 scl_out = 1'b1;
      #30 seen = sda_in;
      #30 scl_out = 1'b0;
      #40;
   endtask : put_bit

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask : send_byte

   // low byte always follows the high byte
   task automatic write(input logic [7:0] ad, input logic [7:0] ct, input logic [7:0] hi, output logic ok);
      logic a0, a1, a2, a3;
      start_cond();
      send_byte(ad, a0);
      send_byte(ct, a1);
      send_byte(hi, a2);
      send_byte(~hi, a3);
      stop_cond();
      ok = a0 & a1 & a2 & a3;
   endtask : write
endmodule : dqd_master

// ### test/dqd_sva.sv
// Checker for the command decoder, watching its top-level ports only.
// Assumes the bind below; one clock domain with a synchronous reset.
`timescale 1ns/1ns
module dqd_sva (
   input wire logic               clk_in,
   input wire logic               reset_in,
   input wire logic               sda_oe_out,
   input wire logic [7:0]         command_byte_out,
   input wire logic [7:0]         upper_data_byte_out,
   input wire dqd_pkg::dqd_word_t output_reg_chan_a_out,
   input wire dqd_pkg::dqd_word_t output_reg_chan_b_out,
   input wire dqd_pkg::dqd_word_t output_reg_chan_c_out,
   input wire dqd_pkg::dqd_word_t output_reg_chan_d_out,
   input wire logic               commit_out
);
   import dqd_pkg::*;
   logic [39:0] all_w;
   logic [9:0]  pick_w;
   logic [2:0]  oe_age;

   assign all_w  = {output_reg_chan_d_out, output_reg_chan_c_out, output_reg_chan_b_out, output_reg_chan_a_out};
   assign pick_w = all_w[command_byte_out[2:1]*10 +: 10];

   // Cycles since the acknowledge was released, saturating
   always_ff @(posedge clk_in) begin
      if (reset_in)
         oe_age <= 3'h7;
      else if ($fell(sda_oe_out))
         oe_age <= 3'h0;
      else if (oe_age != 3'h7)
         oe_age <= oe_age + 3'h1;
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence oe_fall_soon;
      ##[0:3] $fell(sda_oe_out);
   endsequence
   sequence commit_in(m, pd);
      commit_out && command_byte_out[5:4] == m && command_byte_out[0] == pd;
   endsequence
   // Both effects ride on the same bus clock fall, so allow either order
   property at_ack_end(ev);
      ev |-> (oe_age < 3'h4) or oe_fall_soon;
   endproperty

   chk_reset_clears: assert property (disable iff (1'b0)
      reset_in |=> all_w == 40'h0 && command_byte_out == 8'h00 && !commit_out)
      else $error("registers not cleared by reset");
   chk_commit_pulse: assert property (commit_out |=> !commit_out)
      else $error("commit longer than one cycle");
   chk_out_on_commit: assert property ($changed(all_w) |-> commit_out)
      else $error("output word changed without commit");
   chk_commit_at_ack: assert property (at_ack_end(commit_out))
      else $error("commit away from acknowledge end");
   chk_cmd_at_ack: assert property (at_ack_end($changed(command_byte_out)))
      else $error("command byte changed away from acknowledge end");
   chk_upper_at_ack: assert property (at_ack_end($changed(upper_data_byte_out)))
      else $error("upper byte changed away from acknowledge end");
   chk_ack_stands: assert property ($rose(sda_oe_out) |=> sda_oe_out [*6])
      else $error("acknowledge released too early");
   chk_store_only: assert property (commit_in(MODE_STORE, 1'b0) |-> $stable(all_w))
      else $error("store mode changed an output");
   chk_load_one: assert property (commit_in(MODE_LOAD_ONE, 1'b0) |->
      pick_w == {2'h0, upper_data_byte_out})
      else $error("picked output not loaded with data");
   chk_bcast_data: assert property (commit_in(MODE_BROADCAST, 1'b0) ##0 command_byte_out[2] |->
      all_w == {4{2'h0, upper_data_byte_out}})
      else $error("broadcast data not in all outputs");
   chk_bcast_pd: assert property (commit_in(MODE_BROADCAST, 1'b1) ##0 command_byte_out[2] |->
      {all_w[39:38], all_w[29:28], all_w[19:18], all_w[9:8]} == {4{upper_data_byte_out[7:6]}})
      else $error("broadcast power-down code not in all outputs");
endmodule : dqd_sva

bind dqd_decoder dqd_sva dqd_sva_i (.clk_in, .reset_in, .sda_oe_out, .command_byte_out, .upper_data_byte_out,
   .output_reg_chan_a_out, .output_reg_chan_b_out, .output_reg_chan_c_out, .output_reg_chan_d_out, .commit_out);
